// [include/adcoc_map.svh]
`ifndef ADCOC_MAP_SVH
`define ADCOC_MAP_SVH

// ==================================================================
// widths
`define ADCOC_DATA_W          14
`define ADCOC_PIPE_DEPTH      7
`define ADCOC_MV_W            12

// ==================================================================
// register offsets (byte addresses)
`define ADCOC_CTRL_ADDR       12'h000
`define ADCOC_STATUS_ADDR     12'h004
`define ADCOC_REF_ADDR        12'h008
`define ADCOC_DATA_ADDR       12'h00C

// ==================================================================
// field positions and reset values
`define ADCOC_CTRL_DIV_LSB    0
`define ADCOC_CTRL_DIV_MSB    15
`define ADCOC_CTRL_HIGH_LSB   16
`define ADCOC_CTRL_HIGH_MSB   23
`define ADCOC_DIV_RESET       16'h0008
`define ADCOC_HIGH_RESET      8'h04
`define ADCOC_DIV_MIN         16'h0002
`define ADCOC_ST_STANDBY      0
`define ADCOC_ST_FULL_OP      1
`define ADCOC_ST_LOCKED       2
`define ADCOC_ST_TWOS         3
`define ADCOC_ST_DCS          4
`define ADCOC_ST_REFM_LSB     5
`define ADCOC_ST_REFM_MSB     6
`define ADCOC_ST_SLOW         7
`define ADCOC_ST_VALID        8
`define ADCOC_REF_VREF_LSB    0
`define ADCOC_REF_VREF_MSB    11
`define ADCOC_REF_SPAN_LSB    16
`define ADCOC_REF_SPAN_MSB    28

// ==================================================================
// timing
`define ADCOC_CLK_MHZ         125
`define ADCOC_WAKE_TIME_US    7000
`define ADCOC_DISCH_TIME_MS   1000
`define ADCOC_WAKE_CYC        (`ADCOC_WAKE_TIME_US * `ADCOC_CLK_MHZ)
`define ADCOC_DISCH_CYC       (`ADCOC_DISCH_TIME_MS * 1000 * `ADCOC_CLK_MHZ)
`define ADCOC_LOCK_CYCLES     7'd100
`define ADCOC_MIN_RATE_KSPS   1000
`define ADCOC_SLOW_DIV        16'(`ADCOC_CLK_MHZ * 1000 / `ADCOC_MIN_RATE_KSPS)

// ==================================================================
// analog level thresholds in millivolts; mode pin thresholds in sixths of the supply
`define ADCOC_FIXED_LOW_MAX   12'd200
`define ADCOC_HALF_REF_MV     12'd500
`define ADCOC_ONE_REF_MV      12'd1000
`define ADCOC_TIE_MARGIN      12'd20
`define ADCOC_SUPPLY_MARGIN   13'd50
`define ADCOC_MODE_DEN        6
`define ADCOC_MODE_T1         1
`define ADCOC_MODE_T2         3
`define ADCOC_MODE_T3         5

`endif

// [include/adcoc_pkg.sv]
package adcoc_pkg;

  typedef enum logic [1:0] {
    ref_external,
    ref_fixed_half,
    ref_programmable,
    ref_fixed_one
  } adcoc_ref_mode_t;

  typedef enum logic [1:0] {
    pwr_run,
    pwr_standby,
    pwr_waking
  } adcoc_pwr_state_t;

endpackage : adcoc_pkg

// [include/adcoc_pipe_if.sv]
`timescale 1ns/10ps
`default_nettype none
`include "adcoc_map.svh"

interface adcoc_pipe_if;
  logic                      shift_en;
  logic [`ADCOC_DATA_W-1:0]  din;
  logic [`ADCOC_DATA_W-1:0]  dout;

  modport ctrl (output shift_en, output din, input dout);
  modport line (input shift_en, input din, output dout);
endinterface : adcoc_pipe_if

`default_nettype wire

// [rtl/adcoc_delay_line.sv]
`timescale 1ns/10ps
`default_nettype none
`include "adcoc_map.svh"

module adcoc_delay_line (
  // clock and reset
  input  wire logic  pclk,
  input  wire logic  presetn,
  // pipeline port
  adcoc_pipe_if.line p
);

  logic [`ADCOC_DATA_W-1:0] stage_reg [`ADCOC_PIPE_DEPTH];

  // ================================================================
  // one stage per conversion step
  genvar i;
  generate
    for (i = 0; i < `ADCOC_PIPE_DEPTH; i++) begin : g_stage
      // split at elaboration so the first stage never indexes below zero
      if (i == 0) begin : g_first
        always_ff @(posedge pclk or negedge presetn) begin
          if (!presetn) begin
            stage_reg[i] <= '0;
          end else if (p.shift_en) begin
            stage_reg[i] <= p.din;
          end
        end
      end else begin : g_next
        always_ff @(posedge pclk or negedge presetn) begin
          if (!presetn) begin
            stage_reg[i] <= '0;
          end else if (p.shift_en) begin
            stage_reg[i] <= stage_reg[i-1];
          end
        end
      end
    end
  endgenerate

  assign p.dout = stage_reg[`ADCOC_PIPE_DEPTH-1];

endmodule : adcoc_delay_line

`default_nettype wire

// [rtl/adcoc_top.sv]
// Decided for this implementation: the register offsets and the APB slave port.
`timescale 1ns/10ps
`default_nettype none
`include "adcoc_map.svh"

// ==================================================================
module adcoc_top #(
  parameter int unsigned WAKE_CYCLES  = `ADCOC_WAKE_CYC,
  parameter int unsigned DISCH_CYCLES = `ADCOC_DISCH_CYC
) (
  // clock and reset
  input  wire logic                      pclk,
  input  wire logic                      presetn,
  // apb slave
  input  wire logic                      psel,
  input  wire logic                      penable,
  input  wire logic                      pwrite,
  input  wire logic [11:0]               paddr,
  input  wire logic [31:0]               pwdata,
  output logic      [31:0]               prdata,
  output logic                           pready,
  output logic                           pslverr,
  // converter inputs
  input  wire logic [`ADCOC_DATA_W-1:0]  analog_sample,
  input  wire logic                      standby_request_pin,
  input  wire logic [`ADCOC_MV_W-1:0]    sense_mv,
  input  wire logic [`ADCOC_MV_W-1:0]    mode_mv,
  input  wire logic [`ADCOC_MV_W-1:0]    analog_supply_level_mv,
  input  wire logic [`ADCOC_MV_W-1:0]    prog_ref_mv,
  input  wire logic [`ADCOC_MV_W-1:0]    ext_ref_mv,
  // output bus
  output logic      [`ADCOC_DATA_W-1:0]  data_out,
  output logic                           data_oe,
  output logic                           data_valid,
  // internal state views
  output logic                           sample_clk_int,
  output logic                           ref_enable,
  output logic                           bias_enable,
  output logic      [`ADCOC_MV_W-1:0]    ref_vref_mv,
  output logic      [`ADCOC_MV_W:0]      ref_span_mv
);

  adcoc_pipe_if pipe ();

  logic [15:0]                   div_reg;
  logic [7:0]                    high_reg;
  logic [15:0]                   div_eff;
  logic [15:0]                   phase_reg;
  logic                          sample_en;
  logic                          clk_int_next;
  adcoc_pkg::adcoc_pwr_state_t   pwr_reg;
  logic [27:0]                   acc_reg;
  logic [27:0]                   acc_sum;
  logic [27:0]                   need_reg;
  logic [27:0]                   wake_cnt_reg;
  logic [6:0]                    lock_reg;
  logic [2:0]                    fill_reg;
  logic                          twos_reg;
  logic                          dcs_reg;
  logic                          twos_next;
  logic                          dcs_next;
  adcoc_pkg::adcoc_ref_mode_t    ref_mode_reg;
  adcoc_pkg::adcoc_ref_mode_t    ref_mode_next;
  logic [`ADCOC_MV_W-1:0]        vref_next;
  logic [15:0]                   mode_x;
  logic [15:0]                   sup_x;
  logic                          apb_setup;
  logic                          apb_wr;
  logic                          rate_chg;
  logic [31:0]                   rdata_next;
  logic                          hit;
  logic                          err_reg;
  logic                          running;

  // ================================================================
  // apb slave
  assign apb_setup = psel & ~penable;
  assign apb_wr    = psel & penable & pwrite;
  assign pready    = psel & penable;
  assign pslverr   = psel & penable & err_reg;

  assign hit = (paddr == `ADCOC_CTRL_ADDR) || (paddr == `ADCOC_STATUS_ADDR) ||
               (paddr == `ADCOC_REF_ADDR)  || (paddr == `ADCOC_DATA_ADDR);

  always_comb begin
    rdata_next = '0;
    case (paddr)
      `ADCOC_CTRL_ADDR: begin
        rdata_next[`ADCOC_CTRL_DIV_MSB:`ADCOC_CTRL_DIV_LSB]   = div_reg;
        rdata_next[`ADCOC_CTRL_HIGH_MSB:`ADCOC_CTRL_HIGH_LSB] = high_reg;
      end
      `ADCOC_STATUS_ADDR: begin
        rdata_next[`ADCOC_ST_STANDBY] = (pwr_reg == adcoc_pkg::pwr_standby);
        rdata_next[`ADCOC_ST_FULL_OP] = running;
        rdata_next[`ADCOC_ST_LOCKED]  = (lock_reg == 7'h00);
        rdata_next[`ADCOC_ST_TWOS]    = twos_reg;
        rdata_next[`ADCOC_ST_DCS]     = dcs_reg;
        rdata_next[`ADCOC_ST_REFM_MSB:`ADCOC_ST_REFM_LSB] = 2'(ref_mode_reg);
        // clock source too slow for rated performance
        rdata_next[`ADCOC_ST_SLOW]    = (div_eff > `ADCOC_SLOW_DIV);
        rdata_next[`ADCOC_ST_VALID]   = data_valid;
      end
      `ADCOC_REF_ADDR: begin
        rdata_next[`ADCOC_REF_VREF_MSB:`ADCOC_REF_VREF_LSB] = ref_vref_mv;
        rdata_next[`ADCOC_REF_SPAN_MSB:`ADCOC_REF_SPAN_LSB] = ref_span_mv;
      end
      `ADCOC_DATA_ADDR: begin
        rdata_next[`ADCOC_DATA_W-1:0] = data_out;
      end
      default: begin
        rdata_next = '0;
      end
    endcase
  end

  // read data frozen in the setup phase so it holds through the access
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata  <= '0;
      err_reg <= 1'b0;
    end else if (apb_setup) begin
      prdata  <= pwrite ? 32'h0000_0000 : rdata_next;
      err_reg <= ~hit;
    end
  end

  assign rate_chg = apb_wr && (paddr == `ADCOC_CTRL_ADDR) &&
                    (pwdata[`ADCOC_CTRL_DIV_MSB:`ADCOC_CTRL_DIV_LSB] != div_reg);

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      div_reg  <= `ADCOC_DIV_RESET;
      high_reg <= `ADCOC_HIGH_RESET;
    end else if (apb_wr && (paddr == `ADCOC_CTRL_ADDR)) begin
      div_reg  <= pwdata[`ADCOC_CTRL_DIV_MSB:`ADCOC_CTRL_DIV_LSB];
      high_reg <= pwdata[`ADCOC_CTRL_HIGH_MSB:`ADCOC_CTRL_HIGH_LSB];
    end
  end

  // ================================================================
  // sample clock divider
  assign div_eff   = (div_reg < `ADCOC_DIV_MIN) ? `ADCOC_DIV_MIN : div_reg;
  assign sample_en = (phase_reg == 16'h0000);

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      phase_reg <= '0;
    end else if (phase_reg >= div_eff - 16'h0001) begin
      phase_reg <= '0;
    end else begin
      phase_reg <= phase_reg + 16'h0001;
    end
  end

  // stabilizer off: internal clock follows the programmed input high time
  always_comb begin
    if (dcs_reg) begin
      clk_int_next = (phase_reg < (div_eff >> 1));
    end else begin
      clk_int_next = ({8'h00, high_reg} > phase_reg);
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sample_clk_int <= 1'b0;
    end else begin
      sample_clk_int <= clk_int_next;
    end
  end

  // ================================================================
  // mode pin decode, thresholds midway between the four levels
  assign mode_x = 16'({4'h0, mode_mv} * `ADCOC_MODE_DEN);
  assign sup_x  = {4'h0, analog_supply_level_mv};

  always_comb begin
    if (mode_x < 16'(sup_x * `ADCOC_MODE_T1)) begin
      twos_next = 1'b0;
      dcs_next  = 1'b0;
    end else if (mode_x < 16'(sup_x * `ADCOC_MODE_T2)) begin
      twos_next = 1'b0;
      dcs_next  = 1'b1;
    end else if (mode_x < 16'(sup_x * `ADCOC_MODE_T3)) begin
      twos_next = 1'b1;
      dcs_next  = 1'b1;
    end else begin
      twos_next = 1'b1;
      dcs_next  = 1'b0;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      twos_reg <= 1'b0;
      dcs_reg  <= 1'b0;
    end else begin
      twos_reg <= twos_next;
      dcs_reg  <= dcs_next;
    end
  end

  // ================================================================
  // reference decode from the sense level
  always_comb begin
    ref_mode_next = adcoc_pkg::ref_programmable;
    vref_next     = prog_ref_mv;
    if (({1'b0, sense_mv} + `ADCOC_SUPPLY_MARGIN) >= {1'b0, analog_supply_level_mv}) begin
      ref_mode_next = adcoc_pkg::ref_external;
      vref_next     = ext_ref_mv;
    end else if (sense_mv <= `ADCOC_FIXED_LOW_MAX) begin
      ref_mode_next = adcoc_pkg::ref_fixed_one;
      vref_next     = `ADCOC_ONE_REF_MV;
    end else if ((sense_mv + `ADCOC_TIE_MARGIN >= `ADCOC_HALF_REF_MV) &&
                 (sense_mv <= `ADCOC_HALF_REF_MV + `ADCOC_TIE_MARGIN)) begin
      ref_mode_next = adcoc_pkg::ref_fixed_half;
      vref_next     = `ADCOC_HALF_REF_MV;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ref_mode_reg <= adcoc_pkg::ref_fixed_one;
      ref_vref_mv  <= '0;
      ref_span_mv  <= '0;
    end else begin
      ref_mode_reg <= ref_mode_next;
      ref_vref_mv  <= vref_next;
      ref_span_mv  <= {vref_next, 1'b0};
    end
  end

  // reference and bias networks dark while in standby
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ref_enable  <= 1'b0;
      bias_enable <= 1'b0;
    end else begin
      bias_enable <= (pwr_reg != adcoc_pkg::pwr_standby);
      ref_enable  <= (pwr_reg != adcoc_pkg::pwr_standby) &&
                     (ref_mode_reg != adcoc_pkg::ref_external);
    end
  end

  // ================================================================
  // standby and wake-up
  // discharge is modelled as a fraction: each standby cycle adds
  // WAKE/DISCH of a cycle to the recharge debt, capped at a full wake
  assign acc_sum = acc_reg + 28'(WAKE_CYCLES);
  assign running = (pwr_reg == adcoc_pkg::pwr_run);

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pwr_reg      <= adcoc_pkg::pwr_run;
      acc_reg      <= '0;
      need_reg     <= '0;
      wake_cnt_reg <= '0;
    end else begin
      case (pwr_reg)
        adcoc_pkg::pwr_run: begin
          acc_reg  <= '0;
          need_reg <= '0;
          if (standby_request_pin) begin
            pwr_reg <= adcoc_pkg::pwr_standby;
          end
        end
        adcoc_pkg::pwr_standby: begin
          if (!standby_request_pin) begin
            pwr_reg      <= adcoc_pkg::pwr_waking;
            wake_cnt_reg <= need_reg;
          end else if (need_reg < 28'(WAKE_CYCLES)) begin
            if (acc_sum >= 28'(DISCH_CYCLES)) begin
              acc_reg  <= acc_sum - 28'(DISCH_CYCLES);
              need_reg <= need_reg + 28'h000_0001;
            end else begin
              acc_reg <= acc_sum;
            end
          end
        end
        adcoc_pkg::pwr_waking: begin
          if (standby_request_pin) begin
            pwr_reg  <= adcoc_pkg::pwr_standby;
            need_reg <= wake_cnt_reg;
          end else if (wake_cnt_reg == 28'h000_0000) begin
            pwr_reg <= adcoc_pkg::pwr_run;
          end else begin
            wake_cnt_reg <= wake_cnt_reg - 28'h000_0001;
          end
        end
        default: begin
          pwr_reg <= adcoc_pkg::pwr_run;
        end
      endcase
    end
  end

  // ================================================================
  // stabilizer relock after a rate change or when it is switched on
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      lock_reg <= '0;
    end else if ((dcs_next && rate_chg) || (dcs_next && !dcs_reg)) begin
      lock_reg <= `ADCOC_LOCK_CYCLES;
    end else if (!dcs_reg) begin
      lock_reg <= '0;
    end else if (sample_en && (lock_reg != 7'h00)) begin
      lock_reg <= lock_reg - 7'h01;
    end
  end

  // ================================================================
  // conversion pipeline
  assign pipe.shift_en = sample_en;
  assign pipe.din      = analog_sample;

  adcoc_delay_line u_delay (
    .pclk    (pclk),
    .presetn (presetn),
    .p       (pipe)
  );

  // last pipeline step is the output latch, giving eight edges in all
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      data_out <= '0;
    end else if (sample_en) begin
      if (twos_reg) begin
        data_out <= {~pipe.dout[`ADCOC_DATA_W-1], pipe.dout[`ADCOC_DATA_W-2:0]};
      end else begin
        data_out <= pipe.dout;
      end
    end
  end

  // words already in flight at wake are stale, so refill before valid
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      fill_reg <= '0;
    end else if (!running) begin
      fill_reg <= '0;
    end else if (sample_en && (fill_reg != 3'(`ADCOC_PIPE_DEPTH))) begin
      fill_reg <= fill_reg + 3'h1;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      data_oe    <= 1'b0;
      data_valid <= 1'b0;
    end else begin
      data_oe    <= (pwr_reg != adcoc_pkg::pwr_standby);
      data_valid <= running && (fill_reg == 3'(`ADCOC_PIPE_DEPTH)) &&
                    (!dcs_reg || (lock_reg == 7'h00));
    end
  end

endmodule : adcoc_top

`default_nettype wire

// [tb/adcoc_asserts.sv]
`timescale 1ns/10ps
`default_nettype none
`include "adcoc_map.svh"

module adcoc_asserts #(
  parameter int unsigned WAKE_CYCLES  = 20,
  parameter int unsigned DISCH_CYCLES = 100
) (
  // clock and reset
  input wire logic                     pclk,
  input wire logic                     presetn,
  // converter inputs
  input wire logic                     standby_request_pin,
  input wire logic [`ADCOC_MV_W-1:0]   sense_mv,
  input wire logic [`ADCOC_MV_W-1:0]   analog_supply_level_mv,
  input wire logic [`ADCOC_MV_W-1:0]   ext_ref_mv,
  // converter outputs
  input wire logic [`ADCOC_DATA_W-1:0] data_out,
  input wire logic                     data_oe,
  input wire logic                     data_valid,
  input wire logic                     ref_enable,
  input wire logic                     bias_enable,
  input wire logic [`ADCOC_MV_W-1:0]   ref_vref_mv,
  input wire logic [`ADCOC_MV_W:0]     ref_span_mv
);
  // ==========
  // helpers
  logic        ext_sel;
  logic        low_sel;
  int unsigned low_cnt;

  assign ext_sel = ({1'b0, sense_mv} + 13'h0032) >= {1'b0, analog_supply_level_mv};
  assign low_sel = (sense_mv <= 12'h0C8) && !ext_sel;

  // saturates so a long run cannot wrap back into the window
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) low_cnt <= 0;
    else if (standby_request_pin) low_cnt <= 0;
    else if (low_cnt < 1000) low_cnt <= low_cnt + 1;
  end

  // ==========
  // properties
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  sequence s_pin_held;
    standby_request_pin [*3];
  endsequence
  // reference enable lags the decoded mode by one more edge
  sequence s_ext_held;
    (ext_sel && $stable(ext_ref_mv)) [*3];
  endsequence

  a_standby_float: assert property (s_pin_held |=> !data_oe)
    else $error("data bus driven in standby");
  a_standby_bias: assert property (s_pin_held |=> !bias_enable && !ref_enable)
    else $error("bias or reference on in standby");
  a_wake_resume: assert property (low_cnt == WAKE_CYCLES + 8 |-> data_oe)
    else $error("bus not back after wake");
  a_float_quiet: assert property (!data_oe |-> !data_valid)
    else $error("valid while bus floats");
  a_wake_quiet: assert property ($rose(data_oe) |-> !data_valid [*8])
    else $error("valid too soon after wake");
  a_out_hold: assert property ($changed(data_out) |=> $stable(data_out))
    else $error("output word changed twice in a row");
  a_span_twice: assert property ($stable(ref_vref_mv) |-> ref_span_mv == {ref_vref_mv, 1'b0})
    else $error("span is not twice the reference");
  a_ext_ref: assert property (s_ext_held |-> !ref_enable && ref_vref_mv == ext_ref_mv)
    else $error("external reference not taken");
  a_fixed_one: assert property (low_sel [*2] |=> ref_vref_mv == 12'h3E8)
    else $error("grounded sense not one volt");
endmodule : adcoc_asserts

bind adcoc_top adcoc_asserts #(.WAKE_CYCLES(WAKE_CYCLES), .DISCH_CYCLES(DISCH_CYCLES)) adcoc_asserts_i (
  .pclk, .presetn, .standby_request_pin, .sense_mv, .analog_supply_level_mv, .ext_ref_mv,
  .data_out, .data_oe, .data_valid, .ref_enable, .bias_enable, .ref_vref_mv, .ref_span_mv
);

`default_nettype wire

// [tb/adcoc_capture.sv]
`timescale 1ns/10ps
`default_nettype none
`include "adcoc_map.svh"

module adcoc_capture (
  // clock
  input  wire logic                     pclk,
  // sample bus
  input  wire logic [`ADCOC_DATA_W-1:0] data_out,
  input  wire logic                     data_oe,
  input  wire logic                     data_valid,
  // captured words
  output logic      [`ADCOC_DATA_W-1:0] cap_word,
  output logic                          cap_stb
);
  // words are dropped until valid: wake-up and relock time
  always_ff @(posedge pclk) begin
    cap_stb <= 1'b0;
    if (data_oe && data_valid && data_out !== cap_word) begin
      cap_word <= data_out;
      cap_stb  <= 1'b1;
    end
  end
endmodule : adcoc_capture

`default_nettype wire

// [tb/tb_top.sv]
`timescale 1ns/10ps
`default_nettype none
`include "adcoc_map.svh"

module tb_top;
  localparam int D = 4;
  typedef struct packed {
    logic [11:0] mode;
    logic [11:0] sense;
    logic [11:0] vref;
    logic [3:0]  st;
    logic        ren;
  } adcoc_row_t;

  // ==========
  // design pins
  logic        pclk = 1'b0, presetn = 1'b0;
  logic        psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0000_0000;
  logic [13:0] analog_sample = 14'h0000;
  logic        standby_request_pin = 1'b0;
  logic [11:0] sense_mv = 12'h000, mode_mv = 12'h000;
  logic [11:0] supply_mv = 12'hBB8, prog_ref_mv = 12'h2EE, ext_ref_mv = 12'h384;
  logic [31:0] prdata, rd;
  logic        pready, pslverr, data_oe, data_valid, sample_clk_int;
  logic        ref_enable, bias_enable, cap_stb, rerr;
  logic [13:0] data_out, cap_word, exp_w;
  logic [11:0] ref_vref_mv;
  logic [12:0] ref_span_mv;
  logic        twos = 1'b0, chk_on = 1'b0;
  logic [13:0] hist [0:1023];
  int          err_count = 0, checks = 0, cyc = 0, w = 0;
  adcoc_row_t  rows [4] = '{
    '{12'h000, 12'h000, 12'h3E8, 4'hC, 1'b1},
    '{12'h3E8, 12'h1F4, 12'h1F4, 4'h6, 1'b1},
    '{12'h7D0, 12'h2BC, 12'h2EE, 4'hB, 1'b1},
    '{12'hBB8, 12'hBB8, 12'h384, 4'h1, 1'b0}
  };

  adcoc_top #(.WAKE_CYCLES(20), .DISCH_CYCLES(100)) adcoc_top_i (
    .pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready,
    .pslverr, .analog_sample, .standby_request_pin, .sense_mv, .mode_mv,
    .analog_supply_level_mv(supply_mv), .prog_ref_mv, .ext_ref_mv, .data_out,
    .data_oe, .data_valid, .sample_clk_int, .ref_enable, .bias_enable,
    .ref_vref_mv, .ref_span_mv
  );
  adcoc_capture adcoc_capture_i (
    .pclk, .data_out, .data_oe, .data_valid, .cap_word, .cap_stb
  );

  always #4 pclk = ~pclk;

  // ramp input, so neighbouring samples always differ
  always @(posedge pclk) begin
    hist[cyc % 1024] = analog_sample;
    exp_w = hist[(cyc - 2 - 7 * D) % 1024] ^ {twos, 13'h0000};
    if (chk_on && cap_stb) chk(32'(cap_word), 32'(exp_w), "pipeline");
    analog_sample <= analog_sample + 14'h0001;
    cyc++;
  end

  // ==========
  // tasks
  task automatic chk(input logic [31:0] g, input logic [31:0] e, input string m);
    checks++;
    if (g !== e) begin
      err_count++;
      $display("MISMATCH %0t %s got %h want %h", $time, m, g, e);
    end
  endtask : chk

  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] wd);
    int n;
    n = 0;
    psel    <= 1'b1;
    pwrite  <= wr;
    paddr   <= a;
    pwdata  <= wd;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1);
    chk(32'(n), 32'h1, "apb answer");
    rd      = prdata;
    rerr    = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask : apb

  task automatic stby(input int n);
    standby_request_pin <= 1'b1;
    repeat (n) @(posedge pclk);
    chk(32'({data_oe, bias_enable, ref_enable, data_valid}), 32'h0, "standby");
    apb(1'b0, `ADCOC_STATUS_ADDR, 32'h0);
    chk(32'(rd[1:0]), 32'h1, "standby status");
    standby_request_pin <= 1'b0;
    w = 0;
    // bus drives again during waking; valid marks the end of wake and refill
    while (data_valid !== 1'b1 && w < 100) begin
      @(posedge pclk);
      w++;
    end
    chk(32'(data_oe), 32'h1, "bus back");
  endtask : stby

  task automatic duty;
    w = 0;
    repeat (10 * D) begin
      @(posedge pclk);
      if (sample_clk_int === 1'b1) w++;
    end
  endtask : duty

  task automatic final_report;
    if (err_count == 0 && checks > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask : final_report

  // ==========
  // sequence
  initial begin
    repeat (3) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    apb(1'b0, `ADCOC_CTRL_ADDR, 32'h0);
    chk(rd, {8'h00, `ADCOC_HIGH_RESET, `ADCOC_DIV_RESET}, "ctrl reset");
    foreach (rows[i]) begin
      mode_mv  <= rows[i].mode;
      sense_mv <= rows[i].sense;
      repeat (3) @(posedge pclk);
      apb(1'b0, `ADCOC_STATUS_ADDR, 32'h0);
      chk(32'(rd[6:3]), 32'(rows[i].st), "mode");
      apb(1'b0, `ADCOC_REF_ADDR, 32'h0);
      chk(rd, {3'h0, rows[i].vref, 1'b0, 4'h0, rows[i].vref}, "ref");
      chk(32'(ref_enable), 32'(rows[i].ren), "ref enable");
    end
    apb(1'b0, 12'h010, 32'h0);
    chk({31'h0, rerr}, 32'h1, "unmapped");
    // rate kept well above the slowest useful one
    apb(1'b1, `ADCOC_CTRL_ADDR, {16'h0001, 16'(D)});
    apb(1'b0, `ADCOC_CTRL_ADDR, 32'h0);
    chk(rd, {16'h0001, 16'(D)}, "ctrl write");
    mode_mv  <= 12'h000;
    sense_mv <= 12'h000;
    repeat (100) @(posedge pclk);
    chk_on <= 1'b1;
    repeat (200) @(posedge pclk);
    chk_on  <= 1'b0;
    mode_mv <= 12'hBB8;
    repeat (50) @(posedge pclk);
    twos   <= 1'b1;
    chk_on <= 1'b1;
    repeat (200) @(posedge pclk);
    chk_on <= 1'b0;
    duty();
    chk(32'(w), 32'd10, "high time");
    mode_mv <= 12'h3E8;
    repeat (2) @(posedge pclk);
    duty();
    chk(32'(w), 32'(D * 5), "stabilized high time");
    repeat (500) @(posedge pclk);
    apb(1'b1, `ADCOC_CTRL_ADDR, 32'h0001_0006);
    repeat (500) @(posedge pclk);
    chk(32'(data_valid), 32'h0, "relock valid");
    w = 0;
    while (data_valid !== 1'b1 && w < 300) begin
      @(posedge pclk);
      w++;
    end
    chk(32'(data_valid), 32'h1, "locked valid");
    stby(40);
    chk(32'(w >= 49 && w <= 54), 32'h1, "short wake");
    stby(200);
    chk(32'(w >= 61 && w <= 66), 32'h1, "long wake");
    final_report();
  end

  // about 2200 cycles expected; several times that before giving up
  initial begin
    #100000;
    err_count++;
    final_report();
  end
endmodule : tb_top

`default_nettype wire
